// ---- src/dsr_pkg.sv ----
// package for the demodulator status readback bank: register indices, codes, carriers
// assumes an AXI4-Lite master with 32-bit data and word-aligned addresses
package dsr_pkg;
	// ==========================================================
	// register indices (byte address is index times four)
	localparam logic [5:0] IDX_NARROW_GAIN = 6'h00;
	localparam logic [5:0] IDX_TIMING_HI = 6'h01;
	localparam logic [5:0] IDX_TIMING_MID = 6'h02;
	localparam logic [5:0] IDX_TIMING_LO = 6'h03;
	localparam logic [5:0] IDX_PHASE_HI = 6'h04;
	localparam logic [5:0] IDX_PHASE_MID = 6'h05;
	localparam logic [5:0] IDX_PHASE_LO = 6'h06;
	localparam logic [5:0] IDX_LOCK_STATE = 6'h07;
	localparam logic [5:0] IDX_WIDE_GAIN = 6'h08;
	localparam logic [5:0] IDX_SWEEP_HI = 6'h09;
	localparam logic [5:0] IDX_SWEEP_LO = 6'h0a;
	localparam logic [5:0] IDX_INPHASE = 6'h0b;
	localparam logic [5:0] IDX_QUAD = 6'h0c;
	localparam logic [5:0] IDX_NOISE = 6'h0d;
	localparam logic [5:0] IDX_BER_HI = 6'h0e;
	localparam logic [5:0] IDX_BER_LO = 6'h0f;
	localparam logic [5:0] IDX_CARRIER_HI = 6'h10;
	localparam logic [5:0] IDX_CARRIER_MID = 6'h11;
	localparam logic [5:0] IDX_CARRIER_LO = 6'h12;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h21;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h22;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	// ==========================================================
	// fields and codes
	localparam int LOCK_BIT = 0;
	localparam int SAMPLE_W = 6;
	localparam int EVT_W = 3;
	localparam int EVT_LOCK_GAINED = 0;
	localparam int EVT_LOCK_LOST = 1;
	localparam int EVT_BER_DONE = 2;
	localparam int BER_WINDOW_LOG2_DEF = 20;
	localparam logic [15:0] ERR_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [EVT_W-1:0] IRQ_EN_RESET = 3'h0;
	// ==========================================================
	// state codes
	typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} dsr_wr_state_t;
	typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} dsr_rd_state_t;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] narrow_gain;
		logic [23:0] timing_freq;
		logic [23:0] phase_freq;
		logic lock;
		logic [7:0] wide_gain;
		logic [15:0] sweep;
		logic [7:0] noise_power;
		logic [23:0] carrier_one;
	} dsr_loop_t;
	typedef struct packed {
		logic strobe;
		logic [SAMPLE_W-1:0] inphase;
		logic [SAMPLE_W-1:0] quadrature;
	} dsr_symbol_t;
	typedef struct packed {
		logic valid;
		logic error;
	} dsr_bit_t;
endpackage : dsr_pkg

// ---- src/dsr_status_bank.sv ----
// status bank of the demodulator, read-only except the irq enable and clear registers, reached over AXI4-Lite
// assumes all inputs synchronous to clk; loop values arrive live from the demodulator core
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: offset 00 reads live narrowband gain accumulator
// R2: offsets 01-03 read symbol timing accumulator
// R3: offsets 04-06 read carrier phase accumulator
// R4: offset 07 bit 0 shows phase lock
// R5: offset 08 reads wideband gain accumulator top
// R6: offsets 09-0A read sweep accumulator, msb first
// R7: host adds sweep, phase and start frequency
// R8: offset 0B holds in-phase lsbs, per symbol
// R9: offset 0C holds quadrature lsbs, per symbol
// R10: offset 0D reads noise power, higher is worse
// R11: host idles narrowband gain before noise read
// R12: offsets 0E-0F count errors per window
// R13: reads harmless, writes to status ignored
module dsr_status_bank #(
	parameter int ADDR_W = 8,
	parameter int BER_WINDOW_LOG2 = dsr_pkg::BER_WINDOW_LOG2_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// demodulator core
	input wire dsr_pkg::dsr_loop_t loop_in,
	input wire dsr_pkg::dsr_symbol_t symbol_in,
	input wire dsr_pkg::dsr_bit_t bit_in,
	// interrupt
	output logic irq
);
	// ==========================================================
	// parameter checks
	if (ADDR_W < dsr_pkg::IDX_W + dsr_pkg::IDX_LSB)
	begin : g_addr_chk
		$error("ADDR_W too small for the register map");
	end
	if (BER_WINDOW_LOG2 < 1 || BER_WINDOW_LOG2 > 30)
	begin : g_ber_chk
		$error("BER_WINDOW_LOG2 out of range");
	end

	// ==========================================================
	// state
	typedef struct packed {
		dsr_pkg::dsr_wr_state_t wst;
		dsr_pkg::dsr_rd_state_t rst;
		logic aw_got;
		logic [dsr_pkg::IDX_W-1:0] aw_idx;
		logic w_got;
		logic [31:0] wdata;
		logic wstb0;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [dsr_pkg::SAMPLE_W-1:0] i_smp;
		logic [dsr_pkg::SAMPLE_W-1:0] q_smp;
		logic [BER_WINDOW_LOG2-1:0] bit_cnt;
		logic [15:0] err_acc;
		logic [15:0] err_cnt;
		logic lock_d;
		logic [dsr_pkg::EVT_W-1:0] irq_st;
		logic [dsr_pkg::EVT_W-1:0] irq_en;
	} dsr_state_t;

	dsr_state_t state_reg;
	dsr_state_t state_next;

	// ==========================================================
	// helpers
	function automatic logic [15:0] sat_inc(input logic [15:0] acc, input logic inc);
		if (inc && acc != dsr_pkg::ERR_MAX)
			return acc + 16'h0001;
		return acc;
	endfunction : sat_inc

	function automatic logic [dsr_pkg::IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
		return a[dsr_pkg::IDX_LSB +: dsr_pkg::IDX_W];
	endfunction : addr_idx

	// status locations accept a write and drop it
	function automatic logic is_status(input logic [dsr_pkg::IDX_W-1:0] idx);
		return idx <= dsr_pkg::IDX_CARRIER_LO;
	endfunction : is_status

	function automatic logic is_mapped(input logic [dsr_pkg::IDX_W-1:0] idx);
		return is_status(idx) || idx == dsr_pkg::IDX_IRQ_STATUS ||
			idx == dsr_pkg::IDX_IRQ_ENABLE || idx == dsr_pkg::IDX_IRQ_CLEAR;
	endfunction : is_mapped

	// ==========================================================
	// read mux: everything live except the symbol samples, the error count and the irq status and enable registers
	function automatic logic [7:0] read_byte(input logic [dsr_pkg::IDX_W-1:0] idx,
		input dsr_pkg::dsr_loop_t lp, input dsr_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			dsr_pkg::IDX_NARROW_GAIN: v = lp.narrow_gain; // R1
			dsr_pkg::IDX_TIMING_HI: v = lp.timing_freq[23:16]; // R2
			dsr_pkg::IDX_TIMING_MID: v = lp.timing_freq[15:8]; // R2
			dsr_pkg::IDX_TIMING_LO: v = lp.timing_freq[7:0]; // R2
			dsr_pkg::IDX_PHASE_HI: v = lp.phase_freq[23:16]; // R3
			dsr_pkg::IDX_PHASE_MID: v = lp.phase_freq[15:8]; // R3
			dsr_pkg::IDX_PHASE_LO: v = lp.phase_freq[7:0]; // R3
			dsr_pkg::IDX_LOCK_STATE: v[dsr_pkg::LOCK_BIT] = lp.lock; // R4
			dsr_pkg::IDX_WIDE_GAIN: v = lp.wide_gain; // R5
			dsr_pkg::IDX_SWEEP_HI: v = lp.sweep[15:8]; // R6
			dsr_pkg::IDX_SWEEP_LO: v = lp.sweep[7:0]; // R6
			dsr_pkg::IDX_INPHASE: v[dsr_pkg::SAMPLE_W-1:0] = s.i_smp; // R8
			dsr_pkg::IDX_QUAD: v[dsr_pkg::SAMPLE_W-1:0] = s.q_smp; // R9
			dsr_pkg::IDX_NOISE: v = lp.noise_power; // R10
			dsr_pkg::IDX_BER_HI: v = s.err_cnt[15:8]; // R12
			dsr_pkg::IDX_BER_LO: v = s.err_cnt[7:0]; // R12
			dsr_pkg::IDX_CARRIER_HI: v = lp.carrier_one[23:16];
			dsr_pkg::IDX_CARRIER_MID: v = lp.carrier_one[15:8];
			dsr_pkg::IDX_CARRIER_LO: v = lp.carrier_one[7:0];
			dsr_pkg::IDX_IRQ_STATUS: v[dsr_pkg::EVT_W-1:0] = s.irq_st;
			dsr_pkg::IDX_IRQ_ENABLE: v[dsr_pkg::EVT_W-1:0] = s.irq_en;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_byte

	// ==========================================================
	// next state
	always_comb
	begin
		logic [dsr_pkg::EVT_W-1:0] evt;
		logic [dsr_pkg::EVT_W-1:0] clr;
		logic [dsr_pkg::IDX_W-1:0] widx;
		logic [dsr_pkg::IDX_W-1:0] ridx;
		evt = '0;
		clr = '0;
		widx = '0;
		ridx = '0;
		state_next = state_reg;

		// ---------------- write channel ----------------
		case (state_reg.wst)
			dsr_pkg::WR_IDLE:
			begin
				if (s_axi_awvalid && !state_reg.aw_got)
				begin
					state_next.aw_got = 1'b1;
					state_next.aw_idx = addr_idx(s_axi_awaddr);
				end
				if (s_axi_wvalid && !state_reg.w_got)
				begin
					state_next.w_got = 1'b1;
					state_next.wdata = s_axi_wdata;
					state_next.wstb0 = s_axi_wstrb[0];
				end
				if (state_next.aw_got && state_next.w_got)
				begin
					widx = state_next.aw_idx;
					state_next.aw_got = 1'b0;
					state_next.w_got = 1'b0;
					state_next.wst = dsr_pkg::WR_RESP;
					state_next.bresp = is_mapped(widx) ? dsr_pkg::RESP_OKAY :
						dsr_pkg::RESP_SLVERR;
					// status locations: answer okay, touch nothing
					if (state_next.wstb0 && widx == dsr_pkg::IDX_IRQ_ENABLE) // R13
						state_next.irq_en = state_next.wdata[dsr_pkg::EVT_W-1:0];
					if (state_next.wstb0 && widx == dsr_pkg::IDX_IRQ_CLEAR)
						clr = state_next.wdata[dsr_pkg::EVT_W-1:0];
				end
			end
			dsr_pkg::WR_RESP:
			begin
				if (s_axi_bready)
					state_next.wst = dsr_pkg::WR_IDLE;
			end
			default: state_next.wst = dsr_pkg::WR_IDLE;
		endcase

		// ---------------- read channel ----------------
		case (state_reg.rst)
			dsr_pkg::RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					ridx = addr_idx(s_axi_araddr);
					// reading has no effect on any counter or flag
					state_next.rdata = {24'h00_0000, read_byte(ridx, loop_in, state_reg)}; // R13
					state_next.rresp = is_mapped(ridx) ? dsr_pkg::RESP_OKAY :
						dsr_pkg::RESP_SLVERR;
					state_next.rst = dsr_pkg::RD_DATA;
				end
			end
			dsr_pkg::RD_DATA:
			begin
				if (s_axi_rready)
					state_next.rst = dsr_pkg::RD_IDLE;
			end
			default: state_next.rst = dsr_pkg::RD_IDLE;
		endcase

		// ---------------- symbol samples ----------------
		if (symbol_in.strobe)
		begin
			state_next.i_smp = symbol_in.inphase; // R8
			state_next.q_smp = symbol_in.quadrature; // R9
		end

		// ---------------- error counter ----------------
		// saturates rather than wraps so a bad window never reads as a good one
		if (bit_in.valid)
		begin
			state_next.bit_cnt = state_reg.bit_cnt + 1'b1;
			if (&state_reg.bit_cnt)
			begin
				state_next.err_cnt = sat_inc(state_reg.err_acc, bit_in.error); // R12
				state_next.err_acc = '0;
				evt[dsr_pkg::EVT_BER_DONE] = 1'b1;
			end
			else
				state_next.err_acc = sat_inc(state_reg.err_acc, bit_in.error); // R12
		end

		// ---------------- events ----------------
		state_next.lock_d = loop_in.lock;
		evt[dsr_pkg::EVT_LOCK_GAINED] = loop_in.lock && !state_reg.lock_d;
		evt[dsr_pkg::EVT_LOCK_LOST] = !loop_in.lock && state_reg.lock_d;
		// a new event in the clearing cycle survives the clear
		state_next.irq_st = (state_reg.irq_st & ~clr) | evt;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= '0;
			state_reg.irq_en <= dsr_pkg::IRQ_EN_RESET;
		end
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = (state_reg.wst == dsr_pkg::WR_IDLE) && !state_reg.aw_got;
	assign s_axi_wready = (state_reg.wst == dsr_pkg::WR_IDLE) && !state_reg.w_got;
	assign s_axi_bvalid = (state_reg.wst == dsr_pkg::WR_RESP);
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = (state_reg.rst == dsr_pkg::RD_IDLE);
	assign s_axi_rvalid = (state_reg.rst == dsr_pkg::RD_DATA);
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign irq = |(state_reg.irq_st & state_reg.irq_en);

endmodule : dsr_status_bank
`default_nettype wire

// ---- verif/dsr_status_bank_asserts.sv ----
// checker for the status bank: read data against live loop inputs, write replies
// assumes it is bound onto dsr_status_bank with byte address bits [7:2] as index
`timescale 1ns/1ps
`default_nettype none
module dsr_status_bank_asserts #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// axi4-lite
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	// demodulator core
	input wire dsr_pkg::dsr_loop_t loop_in
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [5:0] ri;
	logic rt;
	assign ri = s_axi_araddr[7:2];
	assign rt = s_axi_arvalid && s_axi_arready;
	// ==========================================================
	// read data follows the live value at the taking edge
	property p_narrow;
		rt && ri == dsr_pkg::IDX_NARROW_GAIN |=> s_axi_rdata == {24'h00_0000, $past(loop_in.narrow_gain)};
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow gain read wrong");
	property p_timing;
		rt && ri == dsr_pkg::IDX_TIMING_HI |=> s_axi_rdata[7:0] == $past(loop_in.timing_freq[23:16]);
	endproperty
	a_timing: assert property (p_timing) else $error("timing high byte wrong");
	property p_phase;
		rt && ri == dsr_pkg::IDX_PHASE_LO |=> s_axi_rdata[7:0] == $past(loop_in.phase_freq[7:0]);
	endproperty
	a_phase: assert property (p_phase) else $error("phase low byte wrong");
	property p_lock;
		rt && ri == dsr_pkg::IDX_LOCK_STATE |=> s_axi_rdata == {31'h0000_0000, $past(loop_in.lock)};
	endproperty
	a_lock: assert property (p_lock) else $error("lock read wrong");
	property p_wide;
		rt && ri == dsr_pkg::IDX_WIDE_GAIN |=> s_axi_rdata[7:0] == $past(loop_in.wide_gain);
	endproperty
	a_wide: assert property (p_wide) else $error("wide gain read wrong");
	property p_sweep;
		rt && ri == dsr_pkg::IDX_SWEEP_LO |=> s_axi_rdata[7:0] == $past(loop_in.sweep[7:0]);
	endproperty
	a_sweep: assert property (p_sweep) else $error("sweep low byte wrong");
	property p_noise;
		rt && ri == dsr_pkg::IDX_NOISE |=> s_axi_rdata[7:0] == $past(loop_in.noise_power);
	endproperty
	a_noise: assert property (p_noise) else $error("noise read wrong");
	// ==========================================================
	// writes to status places are answered okay next cycle
	property p_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr[7:2] <= dsr_pkg::IDX_CARRIER_LO
			|=> s_axi_bvalid && s_axi_bresp == dsr_pkg::RESP_OKAY;
	endproperty
	a_wr: assert property (p_wr) else $error("status write reply wrong");
endmodule : dsr_status_bank_asserts
bind dsr_status_bank dsr_status_bank_asserts #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// ---- verif/demod_status_readback_test.sv ----
// self-checking bench for the status bank: loop readback, samples, error window, writes
// assumes design and checker are compiled first; short error window for run time
`timescale 1ns/1ps
`default_nettype none
module demod_status_readback_test;
	localparam int BW = 4;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	dsr_pkg::dsr_loop_t loop_in = '0;
	dsr_pkg::dsr_symbol_t symbol_in = '0;
	dsr_pkg::dsr_bit_t bit_in = '0;
	int fails = 0;
	int compares = 0;
	dsr_status_bank #(.BER_WINDOW_LOG2(BW)) dut_u (.*);
	always #20 clk = ~clk;
	// ==========================================================
	// bus and compare tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a);
		logic b, x;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge clk);
			b = s_axi_rvalid;
			rd_v = s_axi_rdata;
			rs = s_axi_rresp;
			x = s_axi_arready;
			@(posedge clk);
			if (x)
				s_axi_arvalid <= 1'b0;
		end
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic b, x, y;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge clk);
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			x = s_axi_awready;
			y = s_axi_wready;
			@(posedge clk);
			if (x)
				s_axi_awvalid <= 1'b0;
			if (y)
				s_axi_wvalid <= 1'b0;
		end
	endtask : wr
	// ==========================================================
	// scenarios
	task automatic t_loop();
		logic [7:0] e [19];
		logic [23:0] ph;
		logic [23:0] tune;
		logic [15:0] sw;
		localparam logic [23:0] TUNE_START = 24'h00_1000;
		e = '{8'h5a, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'h01, 8'hc3, 8'hbe, 8'hef,
			8'h00, 8'h00, 8'h7e, 8'h00, 8'h00, 8'h24, 8'h68, 8'hac};
		loop_in <= '{8'h5a, 24'h12_3456, 24'h78_9abc, 1'b1, 8'hc3, 16'hbeef, 8'h7e, 24'h24_68ac};
		@(posedge clk);
		// narrow gain held still before the noise read
		repeat (2) @(posedge clk);
		for (int i = 0; i < 19; i++)
			if (i != 11 && i != 12 && i != 14 && i != 15)
			begin
				rd(8'(i * 4));
				chk("status", rd_v, {24'h00_0000, e[i]});
			end
		rd(8'h10);
		ph[23:16] = rd_v[7:0];
		rd(8'h14);
		ph[15:8] = rd_v[7:0];
		rd(8'h18);
		ph[7:0] = rd_v[7:0];
		rd(8'h24);
		sw[15:8] = rd_v[7:0];
		rd(8'h28);
		sw[7:0] = rd_v[7:0];
		// host side tuning sum from the readback bytes
		tune = ph + 24'(sw) + TUNE_START;
		chk("tuning", 32'(tune), 32'h0079_69ab);
		loop_in.lock <= 1'b0;
		@(posedge clk);
		rd(8'h1c);
		chk("lock", rd_v, 32'h0000_0000);
	endtask : t_loop
	task automatic t_sym();
		symbol_in <= '{1'b1, 6'h2b, 6'h15};
		@(posedge clk);
		symbol_in <= '{1'b0, 6'h3f, 6'h00};
		rd(8'h2c);
		chk("inphase", rd_v, 32'h0000_002b);
		rd(8'h30);
		chk("quadrature", rd_v, 32'h0000_0015);
		symbol_in <= '{1'b1, 6'h3f, 6'h00};
		@(posedge clk);
		symbol_in <= '0;
		rd(8'h2c);
		chk("inphase next", rd_v, 32'h0000_003f);
	endtask : t_sym
	task automatic t_ber();
		// error flag without valid must not count
		bit_in <= '{1'b0, 1'b1};
		@(posedge clk);
		for (int i = 0; i < 2 ** BW; i++)
		begin
			bit_in <= '{1'b1, (i < 2 || i == 2 ** BW - 1)};
			@(posedge clk);
		end
		bit_in <= '0;
		@(negedge clk);
		chk("irq masked", irq, 1'b0);
		rd(8'h80);
		chk("window event", rd_v[2], 1'b1);
		rd(8'h38);
		chk("errors hi", rd_v, 32'h0000_0000);
		rd(8'h3c);
		chk("errors lo", rd_v, 32'h0000_0003);
		rd(8'h3c);
		chk("errors reread", rd_v, 32'h0000_0003);
		wr(8'h84, 32'h0000_0004);
		@(negedge clk);
		chk("irq", irq, 1'b1);
		wr(8'h88, 32'h0000_0004);
		@(negedge clk);
		chk("irq cleared", irq, 1'b0);
	endtask : t_ber
	task automatic t_wr();
		wr(8'h00, 32'h0000_00ff);
		chk("write reply", rs, dsr_pkg::RESP_OKAY);
		rd(8'h00);
		chk("after write", rd_v, 32'h0000_005a);
		wr(8'hfc, 32'h0000_0001);
		chk("unmapped write", rs, dsr_pkg::RESP_SLVERR);
		rd(8'hfc);
		chk("unmapped read", {rd_v[29:0], rs}, {30'h0000_0000, dsr_pkg::RESP_SLVERR});
	endtask : t_wr
	task automatic summarize();
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_loop();
		t_sym();
		t_ber();
		t_wr();
		summarize();
	end
	initial
	begin
		#100000;
		fails++;
		summarize();
	end
endmodule : demod_status_readback_test
`default_nettype wire
